// file: hw/tss_cfg.svh
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

// Bus address
`define TSS_ADDR_FIXED     4'h9

// Pointer indices
`define TSS_PTR_TEMP       3'h0
`define TSS_PTR_CONF       3'h1
`define TSS_PTR_HYST       3'h2
`define TSS_PTR_UPPER      3'h3
`define TSS_PTR_ONESHOT    3'h4

// Configuration bit positions
`define TSS_CONF_SHDN      0
`define TSS_CONF_INTMODE   1
`define TSS_CONF_POL       2
`define TSS_CONF_FQ_LO     3
`define TSS_CONF_FQ_HI     4
`define TSS_CONF_ONESHOT   5

// Fault queue encodings and counts
`define TSS_FQ_1           2'h0
`define TSS_FQ_2           2'h1
`define TSS_FQ_4           2'h2
`define TSS_FAULTS_1       3'h1
`define TSS_FAULTS_2       3'h2
`define TSS_FAULTS_4       3'h4
`define TSS_FAULTS_6       3'h6

// Reset values
`define TSS_PTR_RESET      8'h00
`define TSS_CONF_RESET     8'h00
`define TSS_TEMP_RESET     16'h0000
`define TSS_HYST_RESET     16'h4B00
`define TSS_UPPER_RESET    16'h5000
`define TSS_PIN_F_RESET    5'h03

// Synchronised pin vector layout
`define TSS_PIN_SCL        0
`define TSS_PIN_SDA        1
`define TSS_PIN_ADDR_LO    2
`define TSS_PIN_ADDR_HI    4

// Timing
`define TSS_CLK_KHZ        125000
`define TSS_TIMEOUT_US     22500
`define TSS_TIMEOUT_CYCLES ((`TSS_TIMEOUT_US * `TSS_CLK_KHZ) / 1000)
`define TSS_TMO_W          22

`endif

// file: hw/tss_pkg.sv
`include "tss_cfg.svh"

package tss_pkg;

  typedef enum logic [2:0] {
    TSS_IDLE     = 3'b000,
    TSS_ADDR     = 3'b001,
    TSS_ADDR_ACK = 3'b010,
    TSS_WR       = 3'b011,
    TSS_WR_ACK   = 3'b100,
    TSS_RD       = 3'b101,
    TSS_RD_ACK   = 3'b110
  } tss_state_t;

  typedef struct packed {
    logic [4:0]           pin_s1;
    logic [4:0]           pin_s2;
    logic [4:0]           pin_s3;
    logic [4:0]           pin_f;
    logic                 tgl_s1;
    logic                 tgl_s2;
    logic                 tgl_s3;
    tss_state_t           state;
    logic [3:0]           bit_cnt;
    logic [7:0]           shreg;
    logic                 rw;
    logic [1:0]           byte_idx;
    logic [7:0]           ptr;
    logic [7:0]           conf;
    logic [15:0]          hyst;
    logic [15:0]          upper;
    logic [15:0]          temp;
    logic [7:0]           msb_hold;
    logic [`TSS_TMO_W-1:0] tmo_cnt;
    logic                 sda_oe;
    logic                 sda_out;
    logic [2:0]           fcnt;
    logic                 alert_act;
    logic                 alert_oe;
    logic                 alert_out;
    logic                 oneshot_pend;
    logic                 adc_run;
  } tss_core_t;

  typedef struct packed {
    logic [15:0] temp_hold;
    logic        tgl;
  } tss_conv_t;

endpackage

// file: hw/tss_serial_alert.sv
`timescale 1ns/1ps
`include "tss_cfg.svh"

module tss_serial_alert
  import tss_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `TSS_TIMEOUT_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        addr_select_hi_i,
  input  wire logic        addr_select_mid_i,
  input  wire logic        addr_select_lo_i,
  output logic             overtemp_alert_output_o,
  output logic             overtemp_alert_output_oe_o,
  output logic             adc_run_o,
  input  wire logic        conv_clk_i,
  input  wire logic        temp_valid_i,
  input  wire logic [15:0] temp_data_i
);

  localparam tss_core_t CORE_RESET = '{
    state:   TSS_IDLE,
    ptr:     `TSS_PTR_RESET,
    conf:    `TSS_CONF_RESET,
    hyst:    `TSS_HYST_RESET,
    upper:   `TSS_UPPER_RESET,
    temp:    `TSS_TEMP_RESET,
    pin_s1:  `TSS_PIN_F_RESET,
    pin_s2:  `TSS_PIN_F_RESET,
    pin_s3:  `TSS_PIN_F_RESET,
    pin_f:   `TSS_PIN_F_RESET,
    default: '0
  };

  localparam logic [`TSS_TMO_W-1:0] TMO_LAST = `TSS_TMO_W'(TIMEOUT_CYCLES - 1);

  tss_core_t state_reg;
  tss_core_t state_next;
  tss_conv_t conv_reg;
  tss_conv_t conv_next;

  // Byte the slave shifts out for a read of the selected register
  function automatic logic [7:0] rd_byte(input logic [2:0]  ptr,
                                         input logic        second,
                                         input logic [7:0]  conf,
                                         input logic [15:0] temp,
                                         input logic [15:0] hyst,
                                         input logic [15:0] upper);
    logic [15:0] word;
    word = 16'h0000;
    unique case (ptr)
      `TSS_PTR_TEMP:  word = temp;
      `TSS_PTR_HYST:  word = hyst;
      `TSS_PTR_UPPER: word = upper;
      default:        word = 16'h0000;
    endcase
    if (ptr == `TSS_PTR_CONF) begin
      rd_byte = conf;
    end else if (second) begin
      rd_byte = word[7:0];
    end else begin
      rd_byte = word[15:8];
    end
  endfunction

  // Number of consecutive faults needed
  function automatic logic [2:0] faults_needed(input logic [1:0] fq);
    unique case (fq)
      `TSS_FQ_1: faults_needed = `TSS_FAULTS_1;
      `TSS_FQ_2: faults_needed = `TSS_FAULTS_2;
      `TSS_FQ_4: faults_needed = `TSS_FAULTS_4;
      default:   faults_needed = `TSS_FAULTS_6;
    endcase
  endfunction

  // Converter side: hold the sample and flag it with a toggle
  always_comb begin
    conv_next = conv_reg;
    if (temp_valid_i) begin
      conv_next.temp_hold = temp_data_i;
      conv_next.tgl       = ~conv_reg.tgl;
    end
  end

  always_ff @(posedge conv_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv_reg <= '0;
    end else begin
      conv_reg <= conv_next;
    end
  end

  always_comb begin
    logic       scl_hi;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_rise;
    logic       sda_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       tmo_hit;
    logic [6:0] own_addr;
    logic [7:0] b;
    logic       read_clr;
    logic       smp_new;
    logic       over;
    logic       below;
    logic [2:0] need;
    logic [2:0] fcnt_n;
    scl_hi     = 1'b0;
    scl_rise   = 1'b0;
    scl_fall   = 1'b0;
    sda_rise   = 1'b0;
    sda_fall   = 1'b0;
    start_cond = 1'b0;
    stop_cond  = 1'b0;
    tmo_hit    = 1'b0;
    own_addr   = 7'h00;
    b          = 8'h00;
    read_clr   = 1'b0;
    smp_new    = 1'b0;
    over       = 1'b0;
    below      = 1'b0;
    need       = 3'h0;
    fcnt_n     = 3'h0;
    state_next = state_reg;

    // Pin synchronisers: a change counts once stages two and three agree
    state_next.pin_s1 = {addr_select_hi_i, addr_select_mid_i, addr_select_lo_i, sda_i, scl_i};
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.pin_s3 = state_reg.pin_s2;
    state_next.pin_f  = (~(state_reg.pin_s2 ^ state_reg.pin_s3) & state_reg.pin_s2) |
                        ((state_reg.pin_s2 ^ state_reg.pin_s3) & state_reg.pin_f);
    state_next.tgl_s1 = conv_reg.tgl;
    state_next.tgl_s2 = state_reg.tgl_s1;
    state_next.tgl_s3 = state_reg.tgl_s2;

    scl_hi     = state_reg.pin_f[`TSS_PIN_SCL] & state_next.pin_f[`TSS_PIN_SCL];
    scl_rise   = ~state_reg.pin_f[`TSS_PIN_SCL] & state_next.pin_f[`TSS_PIN_SCL];
    scl_fall   = state_reg.pin_f[`TSS_PIN_SCL] & ~state_next.pin_f[`TSS_PIN_SCL];
    sda_rise   = ~state_reg.pin_f[`TSS_PIN_SDA] & state_next.pin_f[`TSS_PIN_SDA];
    sda_fall   = state_reg.pin_f[`TSS_PIN_SDA] & ~state_next.pin_f[`TSS_PIN_SDA];
    start_cond = sda_fall & scl_hi;
    stop_cond  = sda_rise & scl_hi;
    own_addr   = {`TSS_ADDR_FIXED, state_reg.pin_f[`TSS_PIN_ADDR_HI:`TSS_PIN_ADDR_LO]};

    // Bus timeout counts only while SDA is held low in a transfer
    if (state_reg.state != TSS_IDLE && !state_next.pin_f[`TSS_PIN_SDA]) begin
      state_next.tmo_cnt = state_reg.tmo_cnt + `TSS_TMO_W'(1);
    end else begin
      state_next.tmo_cnt = '0;
    end
    tmo_hit = (state_reg.tmo_cnt == TMO_LAST);

    if (start_cond) begin
      state_next.state    = TSS_ADDR;
      state_next.bit_cnt  = 4'h0;
      state_next.byte_idx = 2'h0;
      state_next.sda_oe   = 1'b0;
    end else if (stop_cond || tmo_hit) begin
      state_next.state   = TSS_IDLE;
      state_next.sda_oe  = 1'b0;
      state_next.tmo_cnt = '0;
    end else begin
      unique case (state_reg.state)
        TSS_IDLE: begin
          state_next.sda_oe = 1'b0;
        end
        TSS_ADDR: begin
          if (scl_rise) begin
            state_next.shreg   = {state_reg.shreg[6:0], state_next.pin_f[`TSS_PIN_SDA]};
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          end else if (scl_fall && state_reg.bit_cnt == 4'h8) begin
            if (state_reg.shreg[7:1] == own_addr) begin
              state_next.sda_oe = 1'b1;
              state_next.rw     = state_reg.shreg[0];
              state_next.state  = TSS_ADDR_ACK;
            end else begin
              state_next.state = TSS_IDLE;
            end
          end
        end
        TSS_ADDR_ACK: begin
          if (scl_fall) begin
            state_next.bit_cnt = 4'h0;
            if (state_reg.rw) begin
              read_clr = 1'b1;
              b = rd_byte(state_reg.ptr[2:0], 1'b0, state_reg.conf, state_reg.temp,
                          state_reg.hyst, state_reg.upper);
              state_next.shreg    = b;
              state_next.sda_oe   = ~b[7];
              state_next.byte_idx = 2'h1;
              state_next.state    = TSS_RD;
            end else begin
              state_next.sda_oe = 1'b0;
              state_next.state  = TSS_WR;
            end
          end
        end
        TSS_WR: begin
          if (scl_rise) begin
            state_next.shreg   = {state_reg.shreg[6:0], state_next.pin_f[`TSS_PIN_SDA]};
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          end else if (scl_fall && state_reg.bit_cnt == 4'h8) begin
            state_next.sda_oe = 1'b1;
            state_next.state  = TSS_WR_ACK;
            if (state_reg.byte_idx != 2'h3) begin
              state_next.byte_idx = state_reg.byte_idx + 2'h1;
            end
            unique case (state_reg.byte_idx)
              2'h0: begin
                state_next.ptr = state_reg.shreg;
                if (state_reg.shreg[2:0] == `TSS_PTR_ONESHOT && state_reg.conf[`TSS_CONF_ONESHOT]) begin
                  state_next.oneshot_pend = 1'b1;
                end
              end
              2'h1: begin
                if (state_reg.ptr[2:0] == `TSS_PTR_CONF) begin
                  state_next.conf = state_reg.shreg;
                end
                state_next.msb_hold = state_reg.shreg;
              end
              2'h2: begin
                if (state_reg.ptr[2:0] == `TSS_PTR_HYST) begin
                  state_next.hyst = {state_reg.msb_hold, state_reg.shreg};
                end
                if (state_reg.ptr[2:0] == `TSS_PTR_UPPER) begin
                  state_next.upper = {state_reg.msb_hold, state_reg.shreg};
                end
              end
              default: begin
              end
            endcase
          end
        end
        TSS_WR_ACK: begin
          if (scl_fall) begin
            state_next.sda_oe  = 1'b0;
            state_next.bit_cnt = 4'h0;
            state_next.state   = TSS_WR;
          end
        end
        TSS_RD: begin
          if (scl_rise) begin
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (state_reg.bit_cnt == 4'h8) begin
              state_next.sda_oe = 1'b0;
              state_next.state  = TSS_RD_ACK;
            end else begin
              state_next.shreg  = {state_reg.shreg[6:0], 1'b0};
              state_next.sda_oe = ~state_reg.shreg[6];
            end
          end
        end
        TSS_RD_ACK: begin
          if (scl_rise && state_next.pin_f[`TSS_PIN_SDA]) begin
            state_next.state = TSS_IDLE;
          end else if (scl_fall) begin
            b = rd_byte(state_reg.ptr[2:0], state_reg.byte_idx[0], state_reg.conf, state_reg.temp,
                        state_reg.hyst, state_reg.upper);
            state_next.shreg    = b;
            state_next.sda_oe   = ~b[7];
            state_next.bit_cnt  = 4'h0;
            state_next.byte_idx = state_reg.byte_idx + 2'h1;
            state_next.state    = TSS_RD;
          end
        end
        default: begin
          state_next.state  = TSS_IDLE;
          state_next.sda_oe = 1'b0;
        end
      endcase
    end
    state_next.sda_out = 1'b0;

    // Converter run request and new samples
    smp_new = state_reg.tgl_s2 ^ state_reg.tgl_s3;
    // Judge the sample that arrives now, not the one before it
    if (smp_new) begin
      state_next.temp = conv_reg.temp_hold;
    end
    state_next.adc_run = (~state_next.conf[`TSS_CONF_SHDN] & ~state_next.conf[`TSS_CONF_ONESHOT]) |
                         state_next.oneshot_pend;
    over   = $signed(state_next.temp[15:4]) >= $signed(state_reg.upper[15:4]);
    below  = $signed(state_next.temp[15:4]) < $signed(state_reg.hyst[15:4]);
    need   = faults_needed(state_reg.conf[`TSS_CONF_FQ_HI:`TSS_CONF_FQ_LO]);
    fcnt_n = state_reg.fcnt;

    if (read_clr && state_reg.conf[`TSS_CONF_INTMODE]) begin
      state_next.alert_act = 1'b0;
      state_next.fcnt      = 3'h0;
      fcnt_n               = 3'h0;
    end
    // Shutdown stops evaluation but leaves the alert level alone
    if (smp_new && state_reg.adc_run) begin
      // A trigger written in this same cycle is lost along with the pending one
      state_next.oneshot_pend = state_next.oneshot_pend & ~state_reg.oneshot_pend;
      if (over) begin
        fcnt_n = (fcnt_n >= need) ? need : fcnt_n + 3'h1;
      end else begin
        fcnt_n = 3'h0;
      end
      state_next.fcnt = fcnt_n;
      if (fcnt_n >= need) begin
        state_next.alert_act = 1'b1;
      end else if (!state_reg.conf[`TSS_CONF_INTMODE] && below) begin
        state_next.alert_act = 1'b0;
      end
    end

    // Open drain pin pulls low when the line should read low
    state_next.alert_oe  = state_next.alert_act ^ state_next.conf[`TSS_CONF_POL];
    state_next.alert_out = 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= CORE_RESET;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign sda_o                      = state_reg.sda_out;
  assign sda_oe_o                   = state_reg.sda_oe;
  assign overtemp_alert_output_o    = state_reg.alert_out;
  assign overtemp_alert_output_oe_o = state_reg.alert_oe;
  assign adc_run_o                  = state_reg.adc_run;

endmodule

// file: tb/tss_chk.sv
`timescale 1ns/1ps
module tss_chk #(
  parameter int unsigned TIMEOUT_CYCLES = 200
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic overtemp_alert_output_o,
  input wire logic overtemp_alert_output_oe_o,
  input wire logic adc_run_o
);
  logic [3:0]  fall_q;
  logic [31:0] low_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Falls of SCL since the last start, and cycles of SDA low
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fall_q <= 4'h0;
      low_q  <= 32'h0;
    end else begin
      if (scl_i && $fell(sda_i))
        fall_q <= 4'h0;
      else if ($fell(scl_i) && fall_q != 4'hF)
        fall_q <= fall_q + 4'h1;
      low_q <= sda_i ? 32'h0 : low_q + 32'h1;
    end
  end
  chk_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("device data moved while clock high");
  chk_drive_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o [*5])
    else $error("device drive too short");
  chk_addr_ack_slot: assert property ($rose(sda_oe_o) && fall_q < 4'hA |-> fall_q == 4'h9)
    else $error("address ack outside ninth clock");
  chk_timeout_rel: assert property (low_q > TIMEOUT_CYCLES + 8 |-> !sda_oe_o)
    else $error("data line held past timeout");
  chk_open_drain: assert property (!sda_o && !overtemp_alert_output_o)
    else $error("open drain value not low");
  chk_rst_alert_idle: assert property ($rose(resetn_i) |-> !overtemp_alert_output_oe_o)
    else $error("alert active after reset");
  chk_adc_run_up: assert property ($rose(resetn_i) |-> ##[0:3] adc_run_o)
    else $error("converter not running after reset");
  chk_stop_quiet: assert property (scl_i && $rose(sda_i) |=> !sda_oe_o [*8])
    else $error("device drives after stop");
  cover property ($rose(sda_oe_o) && fall_q == 4'h9);
  cover property ($rose(overtemp_alert_output_oe_o));
  cover property (low_q == TIMEOUT_CYCLES);
endmodule

bind tss_serial_alert tss_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) tss_chk_i (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .overtemp_alert_output_o(overtemp_alert_output_o),
  .overtemp_alert_output_oe_o(overtemp_alert_output_oe_o),
  .adc_run_o(adc_run_o)
);

// file: tb/tss_mst.sv
`timescale 1ns/1ps
module tss_mst (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data moves only while SCL is low, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sda_oe_o <= ~b;
    tick(6);
    scl_o <= 1'b1;
    tick(4);
    r = sda_i;
    tick(4);
    scl_o <= 1'b0;
  endtask
  // SDA falls while SCL high
  task automatic start();
    tick(2);
    sda_oe_o <= 1'b0;
    tick(6);
    scl_o <= 1'b1;
    tick(8);
    sda_oe_o <= 1'b1;
    tick(8);
    scl_o <= 1'b0;
  endtask
  // SDA rises while SCL high
  task automatic stop();
    tick(2);
    sda_oe_o <= 1'b1;
    tick(6);
    scl_o <= 1'b1;
    tick(8);
    sda_oe_o <= 1'b0;
    tick(8);
  endtask
  // Eight bits MSB first, then the receiver's ack
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // Ack keeps the read going, not-acknowledge ends it
  task automatic rb(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~more, r);
  endtask
endmodule

// file: tb/tb_tss_serial_alert.sv
`timescale 1ns/1ps
`include "tss_cfg.svh"
module tb_tss_serial_alert;
  logic        clk_i      = 1'b0;
  logic        conv_clk_i = 1'b0;
  logic        resetn_i   = 1'b0;
  logic [2:0]  sel        = 3'h0;
  logic        tv         = 1'b0;
  logic [15:0] td         = 16'h0000;
  logic [6:0]  dev        = 7'h48;
  logic        m_scl;
  logic        m_oe;
  wire logic   sda_oe;
  wire logic   al_oe;
  wire logic   adc_run;
  wire logic   sda        = ~(m_oe | sda_oe);
  int          errors     = 0;
  int          num_checks = 0;
  always #4 clk_i = ~clk_i;
  always #24 conv_clk_i = ~conv_clk_i;
  tss_serial_alert #(.TIMEOUT_CYCLES(200)) tss_serial_alert_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .scl_i(m_scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe), .addr_select_hi_i(sel[2]), .addr_select_mid_i(sel[1]),
    .addr_select_lo_i(sel[0]), .overtemp_alert_output_o(), .overtemp_alert_output_oe_o(al_oe),
    .adc_run_o(adc_run), .conv_clk_i(conv_clk_i), .temp_valid_i(tv), .temp_data_i(td));
  tss_mst tss_mst_i (.clk_i(clk_i), .sda_i(sda), .scl_o(m_scl), .sda_oe_o(m_oe));
  task automatic report_and_stop;
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp16({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d, output logic ok);
    logic a;
    tss_mst_i.start();
    tss_mst_i.wb({dev, 1'b0}, ok);
    tss_mst_i.wb(p, a);
    ok &= a;
    if (n == 2) begin
      tss_mst_i.wb(d[15:8], a);
      ok &= a;
    end
    if (n > 0) begin
      tss_mst_i.wb(d[7:0], a);
      ok &= a;
    end
    tss_mst_i.stop();
  endtask
  task automatic rd(input int n, output logic [15:0] d, output logic ok);
    logic [7:0] b;
    tss_mst_i.start();
    tss_mst_i.wb({dev, 1'b1}, ok);
    d = 16'h0000;
    for (int i = 0; i < n; i++) begin
      tss_mst_i.rb(i < n - 1, b);
      d = {d[7:0], b};
    end
    tss_mst_i.stop();
  endtask
  task automatic put(input logic [7:0] p, input int n, input logic [15:0] d);
    logic ok;
    wr(p, n, d, ok);
    cmp1(ok, 1'b1);
  endtask
  task automatic get(input logic [7:0] p, input int n, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    put(p, 0, 16'h0000);
    rd(n, d, ok);
    cmp1(ok, 1'b1);
    cmp16(d, e);
  endtask
  task automatic sample(input logic [15:0] t);
    @(posedge conv_clk_i);
    tv <= 1'b1;
    td <= t;
    @(posedge conv_clk_i);
    tv <= 1'b0;
    repeat (6) @(posedge conv_clk_i);
  endtask
  task automatic t_reset;
    logic [15:0] d;
    logic        ok;
    cmp1(~al_oe, 1'b1);
    rd(2, d, ok);
    cmp16(d, 16'h0000);
    get(`TSS_PTR_UPPER, 2, 16'h5000);
    get(`TSS_PTR_HYST, 2, 16'h4B00);
    get(`TSS_PTR_CONF, 1, 16'h0000);
  endtask
  task automatic t_addr;
    logic ok;
    dev = {`TSS_ADDR_FIXED, 3'h1};
    wr(1, 0, 16'h0000, ok);
    cmp1(ok, 1'b0);
    @(posedge clk_i);
    sel <= 3'h5;
    tss_mst_i.tick(8);
    dev = {`TSS_ADDR_FIXED, 3'h5};
    get(1, 1, 16'h0000);
  endtask
  task automatic t_regs;
    put(3, 2, 16'h1900);
    put(2, 2, 16'h1400);
    get(3, 2, 16'h1900);
    put(1, 1, 16'h0018);
    get(1, 1, 16'h0018);
  endtask
  task automatic t_cmp;
    put(1, 1, 16'h0000);
    sample(16'h1900);
    cmp1(~al_oe, 1'b0);
    sample(16'h1500);
    cmp1(~al_oe, 1'b0);
    put(1, 1, 16'h0001);
    sample(16'h1000);
    cmp1(~al_oe, 1'b0);
    put(1, 1, 16'h0000);
    sample(16'hE700);
    cmp1(~al_oe, 1'b1);
    get(0, 2, 16'hE700);
    put(1, 1, 16'h0004);
    sample(16'hE700);
    cmp1(~al_oe, 1'b0);
    sample(16'h1900);
    cmp1(~al_oe, 1'b1);
  endtask
  task automatic t_fq;
    int n [4] = '{1, 2, 4, 6};
    for (int k = 0; k < 4; k++) begin
      put(1, 1, {11'h000, k[1:0], 3'h0});
      sample(16'hE700);
      repeat (n[k] - 1) sample(16'h1900);
      cmp1(~al_oe, 1'b1);
      sample(16'h1900);
      cmp1(~al_oe, 1'b0);
    end
    sample(16'hE700);
  endtask
  task automatic t_int;
    put(1, 1, 16'h000A);
    sample(16'h1900);
    cmp1(~al_oe, 1'b1);
    sample(16'h1900);
    cmp1(~al_oe, 1'b0);
    get(1, 1, 16'h000A);
    cmp1(~al_oe, 1'b1);
    sample(16'h1900);
    cmp1(~al_oe, 1'b1);
    sample(16'h1900);
    cmp1(~al_oe, 1'b0);
    get(1, 1, 16'h000A);
  endtask
  task automatic t_oneshot;
    put(1, 1, 16'h0020);
    cmp1(adc_run, 1'b0);
    put(4, 1, 16'h00A5);
    cmp1(adc_run, 1'b1);
    sample(16'h1000);
    cmp1(adc_run, 1'b0);
    get(1, 1, 16'h0020);
  endtask
  task automatic t_tmo;
    logic a;
    tss_mst_i.start();
    tss_mst_i.wb({dev, 1'b0}, a);
    tss_mst_i.tick(300);
    tss_mst_i.wb(8'h01, a);
    cmp1(a, 1'b1);
    tss_mst_i.stop();
    tss_mst_i.start();
    tss_mst_i.wb({dev, 1'b1}, a);
    tss_mst_i.tick(300);
    cmp1(sda_oe, 1'b0);
    tss_mst_i.stop();
    get(1, 1, 16'h0020);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_addr();
    t_regs();
    t_cmp();
    t_fq();
    t_int();
    t_oneshot();
    t_tmo();
    report_and_stop();
  end
  initial begin
    #700000;
    errors++;
    report_and_stop();
  end
endmodule
